// ### core/pco_regs.svh
// register offsets, field positions, reset values and timing counts
`ifndef PCO_REGS_SVH
`define PCO_REGS_SVH
// ----------------------------------------
// register offsets (byte index on the port)
// ----------------------------------------
`define PCO_ADDR_CTRL 4'h0
`define PCO_ADDR_FLAG 4'h1
`define PCO_ADDR_OFFSET 4'h2
`define PCO_ADDR_SECONDS 4'h3
`define PCO_ADDR_IRQ_STATUS 4'h4
`define PCO_ADDR_IRQ_MASK 4'h5
// ----------------------------------------
// control register fields
// ----------------------------------------
`define PCO_CTRL_SEL_LSB 0
`define PCO_CTRL_OE_BIT 3
`define PCO_CTRL_IE_BIT 4
`define PCO_CTRL_SY_BIT 5
`define PCO_CTRL_RST_BIT 6
// ----------------------------------------
// source codes of the select field
// ----------------------------------------
`define PCO_SEL_32K 3'h0
`define PCO_SEL_TIMER 3'h6
`define PCO_SEL_LOW 3'h7
`define PCO_SEL_PRESC_LO 3'h2
// ----------------------------------------
// reset values loaded from the mirror
// ----------------------------------------
`define PCO_RST_SEL 3'h0
`define PCO_RST_OE 1'b1
`define PCO_RST_IE 1'b0
`define PCO_RST_SY 1'b1
`define PCO_RST_OFFSET 8'h00
`define PCO_RST_MASK 3'h0
// ----------------------------------------
// divider taps and prescaler split
// ----------------------------------------
`define PCO_TAP_8192 1
`define PCO_TAP_1024 4
`define PCO_TAP_64 8
`define PCO_TAP_32 9
`define PCO_TAP_1 14
`define PCO_PRESC_LSB 3
`define PCO_CORR_MASK 6'h00
`endif

// ### core/pco_pkg.sv
// types shared by the clock output block
package pco_pkg;
  // output gate states
  typedef enum logic [1:0] {
    PCO_OFF,
    PCO_ARM,
    PCO_RUN,
    PCO_DRAIN
  } pco_state_t;
  typedef logic [2:0] pco_sel_t;
endpackage

// ### core/pco_sync.sv
// two flip-flop synchroniser for pin levels
`timescale 1ns/100ps
`default_nettype none
module pco_sync #(
  parameter int WIDTH = 1
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage1; // first stage, read only by stage two
  logic [WIDTH-1:0] stage2; // settled copy
  // two registers in a row, nothing taps the first
  always_ff @(posedge core_clk) begin
    if (rst) begin
      stage1 <= '0;
      stage2 <= '0;
    end else begin
      stage1 <= async_in;
      stage2 <= stage1;
    end
  end
  assign sync_out = stage2;
endmodule
`default_nettype wire

// ### core/pco_divider.sv
// oscillator divider chain with prescaler reset and offset correction
`timescale 1ns/100ps
`default_nettype none
`include "pco_regs.svh"
module pco_divider #(
  parameter int CNT_W = 15
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic osc_fall,
  input wire logic presc_clr,
  input wire logic [7:0] osc_offset_value,
  output logic [CNT_W-1:0] div_cnt
);
  logic [CNT_W-1:0] next_div_cnt; // chain value
  logic [7:0] corr_left; // corrections still owed this second
  logic [7:0] next_corr_left;
  logic sec_wrap; // 1 Hz tap about to fall
  logic [7:0] corr_mag; // size of the offset
  // step is 1, or 2 to gain a count, or 0 to lose one
  always_comb begin
    next_div_cnt = div_cnt;
    next_corr_left = corr_left;
    corr_mag = osc_offset_value[7] ? 8'(-osc_offset_value) : osc_offset_value;
    sec_wrap = &div_cnt;
    if (osc_fall) begin
      if (corr_left != 8'h00 && div_cnt[5:0] == `PCO_CORR_MASK && div_cnt[`PCO_TAP_1]) begin
        // spread corrections over the second half of each second
        next_corr_left = corr_left - 8'h01;
        if (!osc_offset_value[7]) begin
          next_div_cnt = div_cnt + CNT_W'(2);
        end
      end else begin
        next_div_cnt = div_cnt + CNT_W'(1);
      end
      if (sec_wrap) begin
        next_corr_left = corr_mag;
      end
    end
    // prescaler clear leaves only the fastest tap (8192) running
    if (presc_clr) begin
      next_div_cnt[CNT_W-1:`PCO_PRESC_LSB] = '0;
    end
  end
  always_ff @(posedge core_clk) begin
    if (rst) begin
      div_cnt <= '0;
      corr_left <= 8'h00;
    end else begin
      div_cnt <= next_div_cnt;
      corr_left <= next_corr_left;
    end
  end
endmodule
`default_nettype wire

// ### core/pco_clock_out.sv
// programmable clock output: source select, gating and register port
`timescale 1ns/100ps
`default_nettype none
`include "pco_regs.svh"
// Notes on behaviour
// - select field routes one of eight sources
// - 32.768 kHz comes straight from oscillator
// - divided taps may carry offset corrections
// - backup supply forces the pin low
// - reset loads sync 1, enable 1, select 000
// - pin low when disabled or select 111
// - reset bit drops pin for selects 010-110
// - timer source ignores the sync bit
// - enable bit starts and stops normal output
// - interrupt sets flag and starts output
// - clearing irq enable keeps running flag output
// - writing flag zero clears it, stops output
// - output requested while enable or flag set
// - synced start at first source falling edge
// - synced stop after bus stop, next fall
// - source change: off and on at falls
// - seconds write clears prescaler like reset
module pco_clock_out
  import pco_pkg::*;
#(
  parameter int CNT_W = 15
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic osc_in,
  input wire logic backup_supply,
  input wire logic timer_irq,
  input wire logic irq_event,
  input wire logic bus_stop,
  output logic freq_out_pin,
  output logic irq
);
  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic osc_s; // settled oscillator level
  logic backup_s; // settled backup state
  logic osc_q; // previous oscillator level
  logic osc_fall; // one-cycle oscillator falling edge
  // oscillator and backup flag come from outside
  pco_sync #(
    .WIDTH(2)
  ) u_sync (
    .core_clk(core_clk),
    .rst(rst),
    .async_in({osc_in, backup_supply}),
    .sync_out({osc_s, backup_s})
  );
  assign osc_fall = osc_q & ~osc_s;

  // ----------------------------------------
  // configuration registers
  // ----------------------------------------
  pco_sel_t freq_select; // source select
  pco_sel_t next_freq_select;
  logic clk_out_enable; // normal output request
  logic next_clk_out_enable;
  logic irq_clk_enable; // interrupt-driven output permit
  logic next_irq_clk_enable;
  logic clk_sync_enable; // edge-aligned gating
  logic next_clk_sync_enable;
  logic irq_clk_flag; // interrupt-driven output request
  logic next_irq_clk_flag;
  logic [7:0] osc_offset_value; // signed correction count
  logic [7:0] next_osc_offset_value;
  logic [2:0] irq_status; // sticky events
  logic [2:0] next_irq_status;
  logic [2:0] irq_mask; // event gate
  logic [2:0] next_irq_mask;
  logic [7:0] next_reg_rdata;
  logic wr_ctrl; // decoded writes
  logic wr_flag;
  logic rst_bit_wr; // one written into reset bit
  logic sec_wr; // seconds register written
  logic presc_clr; // prescaler clear pulse
  logic backup_rise; // entering backup state
  logic backup_q;
  logic run_start; // gate opened this cycle
  // gate state flag, read back on the flag register
  logic gate_on; // gate passes the source

  assign wr_ctrl = reg_wr && reg_addr == `PCO_ADDR_CTRL;
  assign wr_flag = reg_wr && reg_addr == `PCO_ADDR_FLAG;
  assign rst_bit_wr = wr_ctrl && reg_wdata[`PCO_CTRL_RST_BIT];
  assign sec_wr = reg_wr && reg_addr == `PCO_ADDR_SECONDS;
  // seconds write clears the prescaler like the reset bit, without the timer hold
  assign presc_clr = rst_bit_wr | sec_wr;
  assign backup_rise = backup_s & ~backup_q;

  // register writes, flag updates and read mux
  always_comb begin
    next_freq_select = freq_select;
    next_clk_out_enable = clk_out_enable;
    next_irq_clk_enable = irq_clk_enable;
    next_clk_sync_enable = clk_sync_enable;
    next_irq_clk_flag = irq_clk_flag;
    next_osc_offset_value = osc_offset_value;
    next_irq_status = irq_status;
    next_irq_mask = irq_mask;
    next_reg_rdata = 8'h00;
    if (wr_ctrl) begin
      next_freq_select = reg_wdata[`PCO_CTRL_SEL_LSB +: 3];
      next_clk_out_enable = reg_wdata[`PCO_CTRL_OE_BIT];
      // clearing permit leaves the flag alone
      next_irq_clk_enable = reg_wdata[`PCO_CTRL_IE_BIT];
      next_clk_sync_enable = reg_wdata[`PCO_CTRL_SY_BIT];
    end
    if (wr_flag && !reg_wdata[0]) begin
      next_irq_clk_flag = 1'b0;
    end
    // interrupt sets flag, set beats clear
    if (irq_event && irq_clk_enable) begin
      next_irq_clk_flag = 1'b1;
    end
    if (reg_wr && reg_addr == `PCO_ADDR_OFFSET) begin
      next_osc_offset_value = reg_wdata;
    end
    if (reg_wr && reg_addr == `PCO_ADDR_IRQ_MASK) begin
      next_irq_mask = reg_wdata[2:0];
    end
    // read data one cycle later, unmapped reads zero
    if (reg_rd) begin
      unique case (reg_addr)
        `PCO_ADDR_CTRL: begin
          next_reg_rdata = {2'b00, clk_sync_enable, irq_clk_enable, clk_out_enable, freq_select};
        end
        `PCO_ADDR_FLAG: begin
          next_reg_rdata = {5'b0_0000, backup_s, gate_on, irq_clk_flag};
        end
        `PCO_ADDR_OFFSET: begin
          next_reg_rdata = osc_offset_value;
        end
        `PCO_ADDR_IRQ_STATUS: begin
          next_reg_rdata = {5'b0_0000, irq_status};
          // read clears, events of this cycle survive below
          next_irq_status = 3'h0;
        end
        `PCO_ADDR_IRQ_MASK: begin
          next_reg_rdata = {5'b0_0000, irq_mask};
        end
        default: begin
          next_reg_rdata = 8'h00;
        end
      endcase
    end
    // sticky events: flag set, output start, backup entry
    next_irq_status = next_irq_status | {backup_rise, run_start, irq_event && irq_clk_enable};
  end

  // configuration registers
  always_ff @(posedge core_clk) begin
    if (rst) begin
      freq_select <= `PCO_RST_SEL;
      clk_out_enable <= `PCO_RST_OE;
      irq_clk_enable <= `PCO_RST_IE;
      clk_sync_enable <= `PCO_RST_SY;
      irq_clk_flag <= 1'b0;
      osc_offset_value <= `PCO_RST_OFFSET;
      irq_status <= 3'h0;
      irq_mask <= `PCO_RST_MASK;
      reg_rdata <= 8'h00;
      osc_q <= 1'b0;
      backup_q <= 1'b0;
    end else begin
      freq_select <= next_freq_select;
      clk_out_enable <= next_clk_out_enable;
      irq_clk_enable <= next_irq_clk_enable;
      clk_sync_enable <= next_clk_sync_enable;
      irq_clk_flag <= next_irq_clk_flag;
      osc_offset_value <= next_osc_offset_value;
      irq_status <= next_irq_status;
      irq_mask <= next_irq_mask;
      reg_rdata <= next_reg_rdata;
      osc_q <= osc_s;
      backup_q <= backup_s;
    end
  end

  // ----------------------------------------
  // source levels
  // ----------------------------------------
  logic [CNT_W-1:0] div_cnt; // divider chain
  logic [7:0] src_lvl; // level of each source
  logic [7:0] src_q; // previous levels
  logic [7:0] src_fall; // falling edge per source

  pco_divider #(
    .CNT_W(CNT_W)
  ) u_div (
    .core_clk(core_clk),
    .rst(rst),
    .osc_fall(osc_fall),
    .presc_clr(presc_clr),
    .osc_offset_value(osc_offset_value),
    .div_cnt(div_cnt)
  );

  // code 000 is the raw oscillator
  assign src_lvl = {1'b0, timer_irq, div_cnt[`PCO_TAP_1], div_cnt[`PCO_TAP_32],
                    div_cnt[`PCO_TAP_64], div_cnt[`PCO_TAP_1024], div_cnt[`PCO_TAP_8192], osc_s};
  assign src_fall = src_q & ~src_lvl;

  // previous source levels for edge detection
  always_ff @(posedge core_clk) begin
    if (rst) begin
      src_q <= 8'h00;
    end else begin
      src_q <= src_lvl;
    end
  end

  // ----------------------------------------
  // output gate
  // ----------------------------------------
  pco_state_t state; // gate state
  pco_state_t next_state;
  pco_sel_t run_sel; // source latched while running
  pco_sel_t next_run_sel;
  logic stop_seen; // bus stop seen since request dropped
  logic next_stop_seen;
  logic timer_hold; // timer source held low after reset bit
  logic next_timer_hold;
  logic req; // any output request
  logic use_sync; // edge alignment in force
  logic next_pin;

  // either request bit keeps output alive
  assign req = clk_out_enable | irq_clk_flag;
  // timer source never waits for an edge
  assign use_sync = clk_sync_enable && freq_select != `PCO_SEL_TIMER;
  assign gate_on = state == PCO_RUN || state == PCO_DRAIN;
  assign run_start = state != PCO_RUN && next_state == PCO_RUN;

  // gate sequencing
  always_comb begin
    next_state = state;
    next_run_sel = run_sel;
    next_stop_seen = stop_seen;
    next_timer_hold = timer_hold;
    // stop only counts once the requests are gone
    if (req) begin
      next_stop_seen = 1'b0;
    end else if (bus_stop) begin
      next_stop_seen = 1'b1;
    end
    // reset bit on timer source holds pin low
    if (rst_bit_wr && req && freq_select == `PCO_SEL_TIMER) begin
      next_timer_hold = 1'b1;
    end else if (!timer_irq) begin
      next_timer_hold = 1'b0;
    end
    unique case (state)
      PCO_OFF: begin
        if (req && freq_select != `PCO_SEL_LOW) begin
          next_run_sel = freq_select;
          next_state = use_sync ? PCO_ARM : PCO_RUN;
        end
      end
      PCO_ARM: begin
        next_run_sel = freq_select;
        if (!req || freq_select == `PCO_SEL_LOW) begin
          next_state = PCO_OFF;
        end else if (!use_sync || src_fall[freq_select]) begin
          next_state = PCO_RUN;
        end
      end
      PCO_RUN: begin
        // unsynced stop beats a pending source change, else a slow tap keeps the pin
        if (!req && !use_sync) begin
          next_state = PCO_OFF;
        end else if (freq_select != run_sel) begin
          // old source drops at its own fall
          next_state = PCO_DRAIN;
        end else if (!req && (stop_seen || bus_stop)) begin
          next_state = PCO_DRAIN;
        end
      end
      PCO_DRAIN: begin
        // tie low at next falling edge
        if (src_fall[run_sel] || run_sel == `PCO_SEL_TIMER || run_sel == `PCO_SEL_LOW) begin
          // re-arm so the new source starts at its fall
          next_state = PCO_OFF;
        end else if (!req && !use_sync) begin
          // unsynced stop needs no falling edge
          next_state = PCO_OFF;
        end else if (req && freq_select == run_sel) begin
          next_state = PCO_RUN;
        end
      end
    endcase
    // pin low in backup whatever the settings
    // disabled or code 111 gives a low pin
    next_pin = gate_on && next_state != PCO_OFF && !backup_s && run_sel != `PCO_SEL_LOW
               && !(timer_hold && run_sel == `PCO_SEL_TIMER) && src_lvl[run_sel];
  end

  // gate registers; pin is a push-pull flop output
  always_ff @(posedge core_clk) begin
    if (rst) begin
      state <= PCO_OFF;
      run_sel <= `PCO_RST_SEL;
      stop_seen <= 1'b0;
      timer_hold <= 1'b0;
      freq_out_pin <= 1'b0;
    end else begin
      state <= next_state;
      run_sel <= next_run_sel;
      stop_seen <= next_stop_seen;
      timer_hold <= next_timer_hold;
      freq_out_pin <= next_pin;
    end
  end

  // ----------------------------------------
  // interrupt output
  // ----------------------------------------
  // level stays high while any unmasked event is pending
  assign irq = |(irq_status & irq_mask);
endmodule
`default_nettype wire

// ### core/pco_dummy_unused.sv
// no content beyond a note: file intentionally holds only this comment

// ### bench/pco_clock_out_asserts.sv
// concurrent checks on the clock output ports
`timescale 1ns/100ps
`default_nettype none
module pco_clock_out_chk (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic osc_in,
  input wire logic backup_supply,
  input wire logic timer_irq,
  input wire logic irq_event,
  input wire logic bus_stop,
  input wire logic freq_out_pin,
  input wire logic irq
);
  // ----------
  // software shadow
  // ----------
  logic [5:0] ctrl_q, next_ctrl_q;
  logic [2:0] mask_q, next_mask_q;
  logic flag_q, next_flag_q;
  // cycles since a control or flag write, saturating
  logic [6:0] quiet, next_quiet;
  logic quiet_max, clr_pre;
  assign quiet_max = quiet == 7'h7f;
  assign clr_pre = reg_wr && (reg_addr == 4'h3 || (reg_addr == 4'h0 && reg_wdata[6]));
  // next shadow values; a set event beats a clear
  always_comb begin
    next_ctrl_q = (reg_wr && reg_addr == 4'h0) ? reg_wdata[5:0] : ctrl_q;
    next_mask_q = (reg_wr && reg_addr == 4'h5) ? reg_wdata[2:0] : mask_q;
    next_flag_q = flag_q;
    if (reg_wr && reg_addr == 4'h1 && !reg_wdata[0]) next_flag_q = 1'b0;
    if (irq_event && ctrl_q[4]) next_flag_q = 1'b1;
    next_quiet = (reg_wr && reg_addr <= 4'h1) ? 7'h00 : quiet + {6'h00, !quiet_max};
  end
  // register the shadow
  always_ff @(posedge core_clk) begin
    if (rst) begin
      ctrl_q <= 6'h28;
      mask_q <= 3'h0;
      flag_q <= 1'b0;
      quiet <= 7'h00;
    end else begin
      ctrl_q <= next_ctrl_q;
      mask_q <= next_mask_q;
      flag_q <= next_flag_q;
      quiet <= next_quiet;
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  // ----------
  // assertions
  // ----------
  a_backup_low: assert property (backup_supply [*5] |-> !freq_out_pin)
    else $error("pin not low on backup");
  a_rd_ctrl: assert property (reg_rd && reg_addr == 4'h0 |=> reg_rdata[6:0] == {1'b0, ctrl_q})
    else $error("control read mismatch");
  a_rd_idle: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data not idle");
  a_idle_low: assert property (!ctrl_q[5] && !ctrl_q[3] && !flag_q && quiet_max |-> !freq_out_pin)
    else $error("pin high with no request");
  a_sel_low: assert property (ctrl_q[2:0] == 3'h7 && quiet_max |-> !freq_out_pin)
    else $error("pin high on low select");
  a_free_run: assert property (ctrl_q == 6'h08 && quiet_max && !backup_supply
    |-> ##[1:40] $changed(freq_out_pin))
    else $error("direct source not toggling");
  a_timer_follow: assert property ((ctrl_q[3:0] == 4'he && quiet_max && !backup_supply
    && $stable(timer_irq)) [*6] |-> freq_out_pin == timer_irq)
    else $error("pin does not follow timer");
  a_presc_clr: assert property (clr_pre && quiet_max && ctrl_q[3] && ctrl_q[2:0] inside {[3'h2:3'h5]}
    && (reg_addr == 4'h3 || reg_wdata[5:0] == ctrl_q) |-> ##[1:4] !freq_out_pin [*8])
    else $error("pin not low after prescaler clear");
  a_irq_set: assert property (irq_event && ctrl_q[4] && mask_q[0] |-> ##[1:2] irq)
    else $error("interrupt not raised");
  a_irq_masked: assert property (mask_q == 3'h0 |-> !irq)
    else $error("interrupt raised while masked");
  c_event: cover property (irq_event && ctrl_q[4]);
  c_clear: cover property (clr_pre && quiet_max);
  c_backup: cover property ($rose(backup_supply));
endmodule
bind pco_clock_out pco_clock_out_chk pco_clock_out_chk_inst (.core_clk, .rst, .reg_addr, .reg_wdata,
  .reg_wr, .reg_rd, .reg_rdata, .osc_in, .backup_supply, .timer_irq, .irq_event, .bus_stop,
  .freq_out_pin, .irq);
`default_nettype wire

// ### bench/pco_ext_sys.sv
// far side: crystal source and a system clocked by the pin
`timescale 1ns/100ps
`default_nettype none
module pco_ext_sys #(
  parameter int HALF_NS = 163
) (
  input wire logic freq_out_pin,
  output logic osc_in,
  output int rise_cnt
);
  // shortened crystal period keeps runs brief; odd value drifts against core_clk
  initial begin
    osc_in = 1'b0;
    forever #(HALF_NS) osc_in = ~osc_in;
  end
  // the woken system just counts rising edges it receives
  // two-state count starts at zero, one process drives it
  always @(posedge freq_out_pin) rise_cnt = rise_cnt + 1;
endmodule
`default_nettype wire

// ### bench/pco_clock_out_bench.sv
// self-checking bench for the programmable clock output
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin failures++; \
  $display("unexpected %s exp %0h got %0h", nm, e, g); end end
module pco_clock_out_bench;
  localparam int HALF = 163;
  typedef struct {logic [2:0] sel; int div; int w;} pco_row_t;
  // select, divide of crystal, window in cycles
  pco_row_t rows [7] = '{'{3'h0, 1, 640}, '{3'h1, 4, 640}, '{3'h2, 32, 5200}, '{3'h3, 512, 16700},
    '{3'h4, 1024, 16700}, '{3'h5, 32768, 2000}, '{3'h7, 0, 640}};
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00, reg_rdata, rd;
  logic reg_wr = 1'b0, reg_rd = 1'b0, backup_supply = 1'b0, timer_irq = 1'b0;
  logic irq_event = 1'b0, bus_stop = 1'b0, osc_in, freq_out_pin, irq;
  int failures = 0, total_checks = 0, rise_cnt, c0, ex, lo, hi;
  always #10 core_clk = ~core_clk;
  pco_clock_out pco_clock_out_inst (.core_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .osc_in, .backup_supply, .timer_irq, .irq_event, .bus_stop, .freq_out_pin, .irq);
  pco_ext_sys #(.HALF_NS(HALF)) pco_ext_sys_inst (.freq_out_pin, .osc_in, .rise_cnt);
  // ----------
  // bus tasks
  // ----------
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rdc(input logic [3:0] a);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 rd = reg_rdata;
  endtask
  task automatic pulse_event;
    @(posedge core_clk);
    irq_event <= 1'b1;
    @(posedge core_clk);
    irq_event <= 1'b0;
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // watchdog well beyond the planned run
  initial begin
    cyc(60000);
    failures++;
    close_out();
  end
  initial begin
    cyc(6);
    rst <= 1'b0;
    // enables cleared before each select change, sync off
    foreach (rows[i]) begin
      wr(4'h0, 8'h00);
      wr(4'h0, {5'h01, rows[i].sel});
      cyc(40);
      c0 = rise_cnt;
      cyc(rows[i].w);
      ex = rows[i].div == 0 ? 0 : rows[i].w * 20 / (2 * HALF * rows[i].div);
      lo = ex > 0 ? ex - 1 : 0;
      hi = rows[i].div == 0 ? 0 : ex + 1;
      `CHK("rate", 1'b1, (rise_cnt - c0 >= lo && rise_cnt - c0 <= hi))
      $display("rate row %0d done", i);
    end
    rst <= 1'b1;
    cyc(6);
    rst <= 1'b0;
    rdc(4'h0);
    `CHK("ctrl reset", 8'h28, rd)
    rdc(4'hf);
    `CHK("unmapped read", 8'h00, rd)
    c0 = rise_cnt;
    cyc(200);
    `CHK("runs after reset", 1'b1, rise_cnt - c0 > 10)
    wr(4'h2, 8'h85);
    rdc(4'h2);
    `CHK("offset", 8'h85, rd)
    $display("reset test done");
    // synced stop waits for a bus stop
    wr(4'h0, 8'h20);
    c0 = rise_cnt;
    cyc(100);
    `CHK("runs until stop", 1'b1, rise_cnt - c0 > 3)
    @(posedge core_clk);
    bus_stop <= 1'b1;
    @(posedge core_clk);
    bus_stop <= 1'b0;
    cyc(40);
    c0 = rise_cnt;
    cyc(100);
    `CHK("stopped", 1'b1, rise_cnt == c0)
    $display("sync stop test done");
    wr(4'h5, 8'h01);
    rdc(4'h5);
    `CHK("mask", 8'h01, rd)
    wr(4'h0, 8'h10);
    pulse_event();
    cyc(2);
    #1 `CHK("irq", 1'b1, irq)
    rdc(4'h1);
    `CHK("flag", 1'b1, rd[0])
    wr(4'h0, 8'h00);
    c0 = rise_cnt;
    cyc(100);
    `CHK("flag output kept", 1'b1, rise_cnt - c0 > 3)
    rdc(4'h4);
    `CHK("status", 1'b1, rd[0])
    wr(4'h1, 8'h00);
    cyc(20);
    c0 = rise_cnt;
    cyc(150);
    `CHK("flag clear stops", 1'b1, rise_cnt == c0)
    wr(4'h0, 8'h18);
    pulse_event();
    wr(4'h1, 8'h00);
    c0 = rise_cnt;
    cyc(100);
    `CHK("enable keeps output", 1'b1, rise_cnt - c0 > 3)
    wr(4'h5, 8'h00);
    $display("interrupt output test done");
    wr(4'h0, 8'h00);
    wr(4'h0, 8'h0a);
    cyc(130);
    for (int k = 0; k < 800 && freq_out_pin !== 1'b1; k++) @(posedge core_clk);
    wr(4'h0, 8'h4a);
    cyc(4);
    #1 `CHK("reset bit low", 1'b0, freq_out_pin)
    for (int k = 0; k < 800 && freq_out_pin !== 1'b1; k++) @(posedge core_clk);
    wr(4'h3, 8'h00);
    cyc(4);
    #1 `CHK("seconds low", 1'b0, freq_out_pin)
    wr(4'h0, 8'h00);
    wr(4'h0, 8'h09);
    cyc(40);
    wr(4'h0, 8'h49);
    c0 = rise_cnt;
    cyc(200);
    `CHK("fast tap unaffected", 1'b1, rise_cnt - c0 > 1)
    $display("prescaler test done");
    wr(4'h0, 8'h00);
    wr(4'h0, 8'h2e);
    cyc(130);
    timer_irq <= 1'b1;
    cyc(8);
    // drop the timer on the edge; the pin still shows the high level here
    timer_irq <= 1'b0;
    #1 `CHK("timer high", 1'b1, freq_out_pin)
    cyc(8);
    #1 `CHK("timer low", 1'b0, freq_out_pin)
    $display("timer test done");
    wr(4'h0, 8'h00);
    wr(4'h0, 8'h28);
    cyc(40);
    backup_supply <= 1'b1;
    cyc(6);
    c0 = rise_cnt;
    cyc(100);
    `CHK("backup quiet", 1'b1, rise_cnt == c0)
    backup_supply <= 1'b0;
    rdc(4'h4);
    `CHK("backup status", 1'b1, rd[2])
    $display("backup test done");
    close_out();
  end
endmodule
`default_nettype wire
